// file: hdl/psram_pkg.sv
package psram_pkg;
   // ==========================================================
   // bus widths
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   // ==========================================================
   // timing figures in ns (T_PU_US in us), clock period in ns
   localparam int CLK_NS       = 100;
   localparam int T_ACC_NS     = 85;     // address / select to data
   localparam int T_CW_NS      = 70;     // select to end of write
   localparam int T_AW_NS      = 80;     // address valid to end of write
   localparam int T_WP_NS      = 40;     // write pulse
   localparam int T_DW_NS      = 35;     // data setup to end of write
   localparam int T_C1H_NS     = 30;     // select high between accesses
   localparam int T_SLP_NS     = 30;     // sleep pulse
   localparam int T_HOLD_NS    = 32000;  // longest time at one address
   localparam int T_PU_US      = 300;    // standby after power-up / sleep
   localparam int INIT_READS   = 3;
   // least times round up, longest times round down
   localparam int RD_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_NS    = (T_CW_NS > T_AW_NS) ? T_CW_NS : T_AW_NS;
   localparam int WR_CYC   = (WR_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_CYC  = (T_C1H_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLP_CYC  = (T_SLP_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC = T_HOLD_NS / CLK_NS;
   localparam int PU_CYC   = (T_PU_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W    = 16;
   // ==========================================================
   // controller states
   typedef enum logic [2:0] {
      PSRAM_PWRUP = 3'b000,
      PSRAM_IDLE  = 3'b001,
      PSRAM_READ  = 3'b010,
      PSRAM_WRITE = 3'b011,
      PSRAM_GAP   = 3'b100,
      PSRAM_SLEEP = 3'b101
   } psram_state_e;
endpackage : psram_pkg

// file: hdl/psram_host.sv
`timescale 1ns/100ps
module psram_host #(
   parameter int PU_CYCLES = psram_pkg::PU_CYC
) (
   input  wire logic                          clk,
   input  wire logic                          rst,
   // user side
   input  wire logic                          req_valid,
   output logic                               req_ready,
   input  wire logic                          req_write,
   input  wire logic [psram_pkg::ADDR_W-1:0]  req_addr,
   input  wire logic [psram_pkg::DATA_W-1:0]  req_wdata,
   input  wire logic [1:0]                    req_lane_n,
   input  wire logic                          req_lane_mode,
   input  wire logic                          sleep_req,
   output logic                               rd_valid,
   output logic [psram_pkg::DATA_W-1:0]       rd_data,
   output logic                               init_done,
   // memory pins
   output logic [psram_pkg::ADDR_W-1:0]       mem_addr,
   output logic                               chip_select_n,
   output logic                               sleep_control,
   output logic                               output_enable_n,
   output logic                               write_strobe_n,
   output logic                               lower_byte_enable_n,
   output logic                               upper_byte_enable_n,
   input  wire logic [psram_pkg::DATA_W-1:0]  data_in,
   output logic [psram_pkg::DATA_W-1:0]       data_out,
   output logic                               data_oe_n
);
   // ==========================================================
   // state and counters
   psram_pkg::psram_state_e state_ff, nxt_state;
   logic [psram_pkg::CNT_W+4-1:0]  cnt_ff;
   logic [1:0]                     init_rd_ff;
   logic                           done_ff;
   logic                           lmode_cur;
   logic [1:0]                     lane_cur;
   logic                           lmode_ff;
   logic [1:0]                     lane_ff;
   logic [psram_pkg::DATA_W-1:0]   sync1_ff, sync2_ff;
   logic                           cnt_end;

   localparam logic [19:0] RD_END  = 20'(psram_pkg::RD_CYC);
   localparam logic [19:0] WR_END  = 20'(psram_pkg::WR_CYC);
   localparam logic [19:0] GAP_END = 20'(psram_pkg::GAP_CYC);
   localparam logic [19:0] SLP_END = 20'(psram_pkg::SLP_CYC);
   localparam logic [19:0] PU_END  = 20'(PU_CYCLES);

   // end of the current phase
   always_comb begin
      case (state_ff)
         psram_pkg::PSRAM_PWRUP: cnt_end = (cnt_ff >= PU_END);
         psram_pkg::PSRAM_READ:  cnt_end = (cnt_ff >= RD_END + 20'h2);
         psram_pkg::PSRAM_WRITE: cnt_end = (cnt_ff >= WR_END);
         psram_pkg::PSRAM_GAP:   cnt_end = (cnt_ff >= GAP_END);
         psram_pkg::PSRAM_SLEEP: cnt_end = (cnt_ff >= SLP_END) && !sleep_req;
         default:                cnt_end = 1'b1;
      endcase
   end

   // ==========================================================
   // sequencer
   // init reads gate normal use
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         psram_pkg::PSRAM_PWRUP: begin
            if (cnt_end) begin
               nxt_state = done_ff ? psram_pkg::PSRAM_IDLE : psram_pkg::PSRAM_READ;
            end
         end
         psram_pkg::PSRAM_IDLE: begin
            if (sleep_req) begin
               nxt_state = psram_pkg::PSRAM_SLEEP;
            end else if (req_valid) begin
               nxt_state = req_write ? psram_pkg::PSRAM_WRITE : psram_pkg::PSRAM_READ;
            end
         end
         psram_pkg::PSRAM_READ:  if (cnt_end) nxt_state = psram_pkg::PSRAM_GAP;
         psram_pkg::PSRAM_WRITE: if (cnt_end) nxt_state = psram_pkg::PSRAM_GAP;
         psram_pkg::PSRAM_GAP: begin
            if (cnt_end) begin
               nxt_state = done_ff ? psram_pkg::PSRAM_IDLE : psram_pkg::PSRAM_READ;
            end
         end
         // wake goes through full standby wait
         psram_pkg::PSRAM_SLEEP: if (cnt_end) nxt_state = psram_pkg::PSRAM_PWRUP;
         default: nxt_state = psram_pkg::PSRAM_PWRUP;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= psram_pkg::PSRAM_PWRUP;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // phase counter, cleared on each state change
   // read and write phases are far below the hold limit
   always_ff @(posedge clk) begin
      if (rst || nxt_state != state_ff) begin
         cnt_ff <= '0;
      end else if (cnt_ff != '1) begin
         cnt_ff <= cnt_ff + 20'h1;
      end
   end

   // count the start-up reads; sleep exit demands them again
   always_ff @(posedge clk) begin
      if (rst || state_ff == psram_pkg::PSRAM_SLEEP) begin
         init_rd_ff <= '0;
         done_ff    <= 1'b0;
      end else if (!done_ff && state_ff == psram_pkg::PSRAM_READ && cnt_end) begin
         init_rd_ff <= init_rd_ff + 2'h1;
         done_ff    <= (init_rd_ff == 2'(psram_pkg::INIT_READS - 1));
      end
   end

   // latch the request when it is taken
   // address changes only in idle, select high
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_addr  <= '0;
         data_out  <= '0;
         lmode_ff  <= 1'b0;
         lane_ff   <= 2'b00;
      end else if (state_ff == psram_pkg::PSRAM_IDLE && req_valid && !sleep_req) begin
         mem_addr  <= req_addr;
         data_out  <= req_wdata;
         lmode_ff  <= req_lane_mode;
         lane_ff   <= req_lane_n;
      end else if (!done_ff && state_ff != psram_pkg::PSRAM_IDLE) begin
         lane_ff   <= 2'b00;
      end
   end

   assign req_ready = (state_ff == psram_pkg::PSRAM_IDLE) && !sleep_req;
   assign init_done = done_ff;
   // a request taken this edge steers the pins at once rather than a cycle late
   assign lmode_cur = (state_ff == psram_pkg::PSRAM_IDLE) ? req_lane_mode : lmode_ff;
   assign lane_cur  = (state_ff == psram_pkg::PSRAM_IDLE) ? req_lane_n : lane_ff;

   // ==========================================================
   // pin drive, registered so all edges are glitch free
   logic act, wr_pulse;
   assign act      = (state_ff == psram_pkg::PSRAM_READ) || (state_ff == psram_pkg::PSRAM_WRITE);
   // strobe or lanes fall one cycle after select and rise together with it
   // pulse after one setup cycle with select and the held signal low
   assign wr_pulse = (state_ff == psram_pkg::PSRAM_WRITE)
                     && (cnt_ff < WR_END);

   always_ff @(posedge clk) begin
      if (rst) begin
         chip_select_n       <= 1'b1;
         sleep_control       <= 1'b1;
         output_enable_n     <= 1'b1;
         write_strobe_n      <= 1'b1;
         lower_byte_enable_n <= 1'b1;
         upper_byte_enable_n <= 1'b1;
         data_oe_n           <= 1'b1;
      end else begin
         chip_select_n   <= !(nxt_state == psram_pkg::PSRAM_READ
                              || nxt_state == psram_pkg::PSRAM_WRITE);
         // sleep held low only in sleep state
         // low for at least the sleep pulse
         sleep_control   <= (nxt_state != psram_pkg::PSRAM_SLEEP);
         // read enables output, strobe stays high
         output_enable_n <= (nxt_state != psram_pkg::PSRAM_READ);
         // drive data only while output enable high in writes
         data_oe_n       <= (nxt_state != psram_pkg::PSRAM_WRITE);
         if (state_ff == psram_pkg::PSRAM_WRITE || nxt_state == psram_pkg::PSRAM_WRITE) begin
            // lane mode: strobe low across write
            // strobe mode: lanes low, strobe pulsed
            write_strobe_n      <= !(nxt_state == psram_pkg::PSRAM_WRITE
                                     && (lmode_cur || wr_pulse));
            // both lanes from one register edge
            lower_byte_enable_n <= !(nxt_state == psram_pkg::PSRAM_WRITE && !lane_cur[0]
                                     && (!lmode_cur || wr_pulse));
            upper_byte_enable_n <= !(nxt_state == psram_pkg::PSRAM_WRITE && !lane_cur[1]
                                     && (!lmode_cur || wr_pulse));
         end else begin
            write_strobe_n      <= 1'b1;
            lower_byte_enable_n <= !(nxt_state == psram_pkg::PSRAM_READ) || lane_cur[0];
            upper_byte_enable_n <= !(nxt_state == psram_pkg::PSRAM_READ) || lane_cur[1];
         end
      end
   end

   // ==========================================================
   // read data capture through two flops, since the pins are async
   // sample after access time plus two sync stages
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= data_in;
         sync2_ff <= sync1_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_valid <= 1'b0;
         rd_data  <= '0;
      end else begin
         rd_valid <= (state_ff == psram_pkg::PSRAM_READ) && cnt_end && done_ff;
         if (state_ff == psram_pkg::PSRAM_READ && cnt_end) begin
            rd_data <= sync2_ff;
         end
      end
   end

   // ==========================================================
   // checks
   // no drive during read
   a_no_bus_fight: assert property (@(posedge clk) disable iff (rst)
      !output_enable_n |-> data_oe_n) else $error("host drives data during read");
   a_lane_pair: assert property (@(posedge clk) disable iff (rst)
      (act && lane_ff == 2'b00) |=> (lower_byte_enable_n == upper_byte_enable_n))
      else $error("lane enables split");
   a_sleep_width: assert property (@(posedge clk) disable iff (rst)
      $fell(sleep_control) |=> !sleep_control) else $error("sleep pulse too short");
   a_pwrup_idle: assert property (@(posedge clk) disable iff (rst)
      (state_ff == psram_pkg::PSRAM_PWRUP) |-> chip_select_n)
      else $error("access during power-up wait");
   // write keeps select for the full write window
   a_write_len: assert property (@(posedge clk) disable iff (rst)
      $rose(state_ff == psram_pkg::PSRAM_WRITE) |-> !chip_select_n [*1] ##1 !chip_select_n)
      else $error("write select too short");
   a_read_strobe: assert property (@(posedge clk) disable iff (rst)
      !output_enable_n |-> write_strobe_n) else $error("strobe low during read");
   // select rises within 8 cycles of falling, well inside hold limit
   a_sel_bound: assert property (@(posedge clk) disable iff (rst)
      $fell(chip_select_n) |-> ##[1:8] chip_select_n) else $error("select held too long");
   a_gap_standby: assert property (@(posedge clk) disable iff (rst)
      (state_ff == psram_pkg::PSRAM_GAP) |-> chip_select_n && data_oe_n)
      else $error("bus active in gap");

   a_strobe_write: assert property (@(posedge clk) disable iff (rst)
      $fell(write_strobe_n) && !lmode_ff |-> !chip_select_n && !data_oe_n
      && !(lower_byte_enable_n && upper_byte_enable_n)) else $error("strobe write not set up");
   a_lane_write: assert property (@(posedge clk) disable iff (rst)
      ($fell(lower_byte_enable_n) || $fell(upper_byte_enable_n)) && lmode_ff
      && (state_ff == psram_pkg::PSRAM_WRITE) |-> !write_strobe_n && $past(!write_strobe_n))
      else $error("lane write without strobe");

   // write is live while select, strobe and at least one lane are low together
   logic wr_live;
   assign wr_live = !chip_select_n && !write_strobe_n
                    && !(lower_byte_enable_n && upper_byte_enable_n);
   a_wr_window: assert property (@(posedge clk) disable iff (rst)
      $fell(wr_live) |-> $past(!chip_select_n, 2) && $past(!data_oe_n, 2)
      && ($past(mem_addr, 2) == mem_addr) && ($past(data_out, 2) == data_out))
      else $error("write window too short");

   // selected time at one address; refresh starves past the limit
   localparam logic [19:0] HOLD_END = 20'(psram_pkg::HOLD_CYC);
   logic [19:0] sel_cnt_ff;
   always_ff @(posedge clk) begin
      if (rst || chip_select_n) begin
         sel_cnt_ff <= '0;
      end else if (sel_cnt_ff != '1) begin
         sel_cnt_ff <= sel_cnt_ff + 20'h1;
      end
   end
   a_addr_hold: assert property (@(posedge clk) disable iff (rst)
      sel_cnt_ff < HOLD_END) else $error("address held past refresh limit");

   // standby time since reset or wake, saturating at the wait length
   logic [19:0] stby_cnt_ff;
   always_ff @(posedge clk) begin
      if (rst || !sleep_control) begin
         stby_cnt_ff <= '0;
      end else if (stby_cnt_ff < PU_END) begin
         stby_cnt_ff <= stby_cnt_ff + 20'h1;
      end
   end
   a_wake_wait: assert property (@(posedge clk) disable iff (rst)
      !chip_select_n |-> (stby_cnt_ff >= PU_END)) else $error("access before standby wait");
   a_sleep_select: assert property (@(posedge clk) disable iff (rst)
      !sleep_control |-> chip_select_n) else $error("select low while asleep");
   a_init_gate: assert property (@(posedge clk) disable iff (rst)
      req_ready |-> done_ff && (init_rd_ff == 2'(psram_pkg::INIT_READS)))
      else $error("user access before start-up reads");

endmodule // psram_host

// file: dv/psram_dev_model.sv
`timescale 1ns/100ps
// ==========================================================
// memory device seen across the pins; counts host-side slips
module psram_dev_model (
   input  wire logic [psram_pkg::ADDR_W-1:0] mem_addr,
   input  wire logic                         chip_select_n,
   input  wire logic                         sleep_control,
   input  wire logic                         output_enable_n,
   input  wire logic                         write_strobe_n,
   input  wire logic                         lower_byte_enable_n,
   input  wire logic                         upper_byte_enable_n,
   input  wire logic [psram_pkg::DATA_W-1:0] data_out,
   input  wire logic                         data_oe_n,
   input  wire logic                         slow,
   output logic [psram_pkg::DATA_W-1:0]      data_in,
   output int                                viol
);
   logic [psram_pkg::DATA_W-1:0] mem [int];
   logic [psram_pkg::DATA_W-1:0] word;
   logic [psram_pkg::DATA_W-1:0] last = 16'h0000;
   logic                         rd_en;
   logic                         rd_dly;
   logic                         drive;
   logic                         wr_act;
   realtime                      t_cs = 0, t_adr = 0, t_dat = 0, t_wr = 0;
   realtime                      t_slp = -1000, t_wake = 0;
   int                           reads = 0;
   assign rd_en  = !chip_select_n && sleep_control && !output_enable_n && write_strobe_n &&
                   !(lower_byte_enable_n && upper_byte_enable_n);
   // slow mode: data late but inside the access limit
   assign #80 rd_dly = rd_en;
   assign drive  = slow ? (rd_en && rd_dly) : rd_en;
   assign wr_act = !chip_select_n && sleep_control && !write_strobe_n &&
                   !(lower_byte_enable_n && upper_byte_enable_n);
   // released lines show the inverse of the last value, never a stale match
   always @* begin
      word = mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : 16'h5a3c;
      if (drive) last = word;
   end
   assign data_in = drive ? word : ~last;
   // store each lane while strobe and its enable are low
   always @* begin
      if (wr_act && !data_oe_n) begin
         if (!lower_byte_enable_n) mem[int'(mem_addr)][7:0] = data_out[7:0];
         if (!upper_byte_enable_n) mem[int'(mem_addr)][15:8] = data_out[15:8];
      end
   end
   always @(negedge chip_select_n) t_cs = $realtime;
   always @(mem_addr) t_adr = $realtime;
   always @(data_out) t_dat = $realtime;
   always @(posedge rd_en) reads++;
   // host must not fight the device on the data lines
   always @(drive, data_oe_n) if (drive && !data_oe_n) viol++;
   // write setup figures, and three reads after waking
   always @(posedge wr_act) begin
      t_wr = $realtime;
      if (reads < 3) viol++;
   end
   // the power-up fall from unknown is not the end of a write
   always @(negedge wr_act) if (t_wr > 0) begin
      if ($realtime - t_cs < 70 || $realtime - t_adr < 80) viol++;
      if ($realtime - t_wr < 40 || $realtime - t_dat < 35) viol++;
   end
   // one address never held selected past the refresh limit
   always @(posedge chip_select_n)
      if ($realtime - t_cs > 32000 && $realtime - t_adr > 32000) viol++;
   // sleep halts refresh: contents are gone
   always @(negedge sleep_control) begin
      t_slp = $realtime;
      mem.delete();
   end
   // sleep pulse width and standby before first access
   always @(posedge sleep_control) begin
      if ($realtime - t_slp < 30) viol++;
      t_wake = $realtime;
      reads = 0;
   end
   always @(negedge chip_select_n) if ($realtime - t_wake < 300000) viol++;
endmodule // psram_dev_model

// file: dv/psram_host_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module psram_host_test;
   logic                         clk, rst, req_valid, req_write, req_lane_mode, sleep_req, slow;
   logic [psram_pkg::ADDR_W-1:0] req_addr, mem_addr;
   logic [psram_pkg::DATA_W-1:0] req_wdata, rd_data, data_in, data_out;
   logic [1:0]                   req_lane_n;
   logic                         req_ready, rd_valid, init_done, chip_select_n, sleep_control;
   logic                         output_enable_n, write_strobe_n, data_oe_n;
   logic                         lower_byte_enable_n, upper_byte_enable_n;
   int                           fails = 0, samples_checked = 0, viol, k;
   logic [15:0]                  ref_mem [int];
   logic [psram_pkg::ADDR_W-1:0] addrs [$];
   psram_host psram_host_inst (.clk(clk), .rst(rst), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_lane_n(req_lane_n), .req_lane_mode(req_lane_mode),
      .sleep_req(sleep_req), .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done),
      .mem_addr(mem_addr), .chip_select_n(chip_select_n), .sleep_control(sleep_control),
      .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
      .lower_byte_enable_n(lower_byte_enable_n), .upper_byte_enable_n(upper_byte_enable_n),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
   psram_dev_model psram_dev_model_inst (.mem_addr(mem_addr), .chip_select_n(chip_select_n),
      .sleep_control(sleep_control), .output_enable_n(output_enable_n),
      .write_strobe_n(write_strobe_n), .lower_byte_enable_n(lower_byte_enable_n),
      .upper_byte_enable_n(upper_byte_enable_n), .data_out(data_out), .data_oe_n(data_oe_n),
      .slow(slow), .data_in(data_in), .viol(viol));
   // ==========================================================
   // clock, closing report and bounded waits
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic end_sim();
      $display("counts: %0d checked, %0d mismatches", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // a wait that runs out of cycles ends the run
   task automatic guard(input int lim);
      if (k >= lim) begin
         fails++;
         $display("mismatch wait_bound expected %0d seen %0d", lim - 1, k);
         end_sim();
      end
   endtask
   // one request through the user handshake; reads compared on enabled lanes only
   task automatic access(input logic wr, input logic [20:0] a, input logic [15:0] d,
                         input logic [1:0] ln, input logic md);
      logic [15:0] m;
      m = {{8{~ln[1]}}, {8{~ln[0]}}};
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      req_lane_n <= ln;
      req_lane_mode <= md;
      k = 0;
      do begin @(posedge clk); k++; end while (req_ready !== 1'b1 && k < 4000);
      guard(4000);
      req_valid <= 1'b0;
      if (wr) begin
         ref_mem[int'(a)] = (ref_mem[int'(a)] & ~m) | (d & m);
         // let an edge pass so the next call never re-raises valid in this step
         @(posedge clk);
      end else begin
         k = 0;
         do begin @(posedge clk); k++; end while (rd_valid !== 1'b1 && k < 20);
         guard(20);
         // lane data matches what was stored
         `CHK("rd_data", ref_mem[int'(a)] & m, rd_data & m)
      end
   endtask
   // host never drives the lines while a read has them
   always @(posedge clk) if (!rst && chip_select_n === 1'b0 && output_enable_n === 1'b0)
      `CHK("host_drive_on_read", 1'b1, data_oe_n)
   // ==========================================================
   // main sequence
   initial begin
      {rst, req_valid, req_write, req_lane_mode, sleep_req, slow} = 6'b100000;
      req_addr = '0;
      req_wdata = '0;
      req_lane_n = 2'b11;
      void'($urandom(32'h4fa56633));
      repeat (8) @(posedge clk);
      `CHK("reset_select", 1'b1, chip_select_n)
      `CHK("reset_sleep", 1'b1, sleep_control)
      rst <= 1'b0;
      for (int pass = 0; pass < 2; pass++) begin
         k = 0;
         do begin @(posedge clk); k++; end while (req_ready !== 1'b1 && k < 3400);
         guard(3400);
         `CHK("init_done", 1'b1, init_done)
         ref_mem.delete();
         addrs.delete();
         for (int i = 0; i < 16; i++) begin
            addrs.push_back(21'($urandom));
            access(1'b1, addrs[i], 16'($urandom), 2'b00, 1'($urandom));
         end
         // partial lanes, both write modes, prompt and slow device
         for (int i = 0; i < 50; i++) begin
            slow <= 1'($urandom);
            access(1'($urandom), addrs[$urandom % 16], 16'($urandom),
                   2'($urandom % 3), 1'($urandom));
         end
         for (int i = 0; i < 16; i++) access(1'b0, addrs[i], 16'h0000, 2'b00, 1'b0);
         $display("test random access pass %0d done", pass);
         if (pass == 0) begin
            sleep_req <= 1'b1;
            k = 0;
            do begin @(posedge clk); k++; end while (sleep_control !== 1'b0 && k < 20);
            guard(20);
            sleep_req <= 1'b0;
            @(posedge clk);
            `CHK("sleep_held", 1'b0, sleep_control)
         end
      end
      `CHK("device_rule_slips", 0, viol)
      end_sim();
   end
endmodule // psram_host_test
